// ### logic/bms_gate_if.sv
// link between the mode sequencer and its half-bridge gate timer
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface bms_gate_if;
  import bms_pkg::*;
  logic oscRun;
  logic hsEnable;
  logic [CNT_W-1:0] halfCount;
  logic lowSideGate;
  logic highSideGate;
  logic cycleEnd;

  modport seq (output oscRun, output hsEnable, output halfCount,
               input lowSideGate, input highSideGate, input cycleEnd);
  modport drv (input oscRun, input hsEnable, input halfCount,
               output lowSideGate, output highSideGate, output cycleEnd);
endinterface

// ### logic/bms_gate_timer.sv
// complementary half-bridge gate timer with fixed dead interval
// assumes halfCount exceeds the dead count by at least one cycle
`timescale 1ns/100ps
module bms_gate_timer
  import bms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  bms_gate_if.drv gate
);

  localparam logic [CNT_W-1:0] DEAD_C = CNT_W'(DEAD_CYC);

  bms_phase_type phase_q, phase_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lowSide_q, lowSide_d;
  logic highSide_q, highSide_d;
  logic [CNT_W-1:0] onCycles;
  logic endOfLow;

  // equal on-times keep 50% duty: each half is on-time plus dead time
  assign onCycles = gate.halfCount - DEAD_C;

  // phase sequencing
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q + CNT_W'(1);
    endOfLow = 1'b0;
    if (!gate.oscRun) begin
      phase_d = PH_LOW_ON;
      cnt_d = '0;
    end else begin
      case (phase_q)
        PH_LOW_ON: begin
          if (cnt_q >= onCycles - CNT_W'(1)) begin
            phase_d = PH_DEAD_A;
            cnt_d = '0;
            endOfLow = 1'b1;
          end
        end
        PH_HIGH_ON: begin
          if (cnt_q >= onCycles - CNT_W'(1)) begin
            phase_d = PH_DEAD_B;
            cnt_d = '0;
          end
        end
        PH_DEAD_A: begin
          if (cnt_q >= DEAD_C - CNT_W'(1)) begin
            phase_d = PH_HIGH_ON;
            cnt_d = '0;
          end
        end
        PH_DEAD_B: begin
          if (cnt_q >= DEAD_C - CNT_W'(1)) begin
            phase_d = PH_LOW_ON;
            cnt_d = '0;
          end
        end
        default: begin
          phase_d = PH_LOW_ON;
          cnt_d = '0;
        end
      endcase
    end
    // stopped oscillator holds both gates low
    lowSide_d = gate.oscRun && (phase_d == PH_LOW_ON);
    // high side waits for its floating supply
    highSide_d = gate.oscRun && gate.hsEnable && (phase_d == PH_HIGH_ON);
  end

  // phase registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_q <= PH_LOW_ON;
      cnt_q <= '0;
      lowSide_q <= 1'b0;
      highSide_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      lowSide_q <= lowSide_d;
      highSide_q <= highSide_d;
    end
  end

  assign gate.lowSideGate = lowSide_q;
  assign gate.highSideGate = highSide_q;
  assign gate.cycleEnd = endOfLow; // one pulse at each low-side turn-off

endmodule // bms_gate_timer

// ### logic/bms_pkg.sv
// shared constants and mode encoding for the ballast mode sequencer
// assumes a 100 MHz system clock and comparator flags already synchronous
package bms_pkg;

  // clock rate and derived cycle counts
  localparam int CLK_MHZ = 100;
  // least non-overlap between opposite gate turn-on, in ns (rounded up)
  localparam int DEAD_NS = 1600;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  // half period of the bridge at the preheat frequency, in ns
  localparam int PREHEAT_HALF_NS = 10000;
  localparam int PREHEAT_HALF_CYC = (PREHEAT_HALF_NS * CLK_MHZ) / 1000;
  // half period at the elevated soft-start frequency, in ns
  localparam int SOFT_HALF_NS = 5000;
  localparam int SOFT_HALF_CYC = (SOFT_HALF_NS * CLK_MHZ) / 1000;
  // number of bridge cycles spent at soft-start frequency
  localparam logic [3:0] SOFT_CYCLES = 4'h8;

  // consecutive overcurrent events that force a fault
  localparam logic [6:0] OC_EVENTS = 7'h41;
  localparam int CNT_W = 12;

  // operating modes
  typedef enum logic [2:0] {
    MODE_LOCKOUT = 3'b000,
    MODE_PREHEAT = 3'b001,
    MODE_IGN_DISCH = 3'b010,
    MODE_IGNITION = 3'b011,
    MODE_RUN = 3'b100,
    MODE_FAULT = 3'b101
  } bms_mode_type;

  // gate driver phases
  typedef enum logic [1:0] {
    PH_LOW_ON = 2'b00,
    PH_DEAD_A = 2'b01,
    PH_HIGH_ON = 2'b10,
    PH_DEAD_B = 2'b11
  } bms_phase_type;

endpackage

// ### logic/bms_sequencer.sv
// ballast mode sequencer: lockout, preheat, ignition, run and fault
// assumes every comparator flag arrives synchronous to clk_sys
//
// How it works
// - lockout holds both gates low, oscillator stopped, timer node grounded.
// - leave lockout when supply is good and shutdown sense is below release.
// - refresh floating supply each low-side on-time; high side waits for it.
// - gates complementary at 50% duty with 1.6 us dead interval.
// - entering preheat releases the timer node grounding switch.
// - preheat starts at soft-start frequency then steps to preheat frequency.
// - frequency-ramp node stays grounded through preheat.
// - first timer crossing of upper level starts ignition, discharging to lower.
// - at lower level release discharge and ramp switches; frequency sweeps down.
// - second upper crossing enters run and enables the event counter.
// - preheat enables overcurrent comparison and 65-event counter.
// - ignition overcurrent pulls ramp node to raise frequency, each cycle.
// - run disables regulation; 65 consecutive events latch all gates low.
// - ignition ignores shutdown and end-of-life faults.
// - preheat and ignition use the high boost gain setting.
// - a low-side cycle without an event decrements the counter.
// - overcurrent counts only while the low-side gate is on.
// - fault grounds the timer node and frequency-ramp node.
// - fault returns to lockout on supply loss or shutdown above threshold.
`timescale 1ns/100ps
module bms_sequencer
  import bms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic supplyAboveOn,
  input wire logic shutdownBelowRelease,
  input wire logic shutdownAboveTrip,
  input wire logic lifetimeWindowFault,
  input wire logic floatingSupplyOk,
  input wire logic timerAboveUpper,
  input wire logic timerBelowLower,
  input wire logic currentAboveThreshold,
  input wire logic boostPwmIn,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic bootstrapOn,
  output logic boost_gate_out,
  output logic timerDischarge,
  output logic rampGround,
  output logic ignitionRegPull,
  output logic softStartActive,
  output logic boostHighGain,
  output logic overcurrentCountEnable,
  output logic lifetimeSenseEnable,
  output logic [2:0] modeState
);

  bms_gate_if gate ();

  bms_gate_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .gate(gate)
  );

  bms_mode_type mode_q, mode_d;
  logic [6:0] evtCnt_q, evtCnt_d;
  logic evtSeen_q, evtSeen_d;
  logic [3:0] softCnt_q, softCnt_d;
  logic hsStarted_q, hsStarted_d;
  logic boostOk_q, boostOk_d;
  logic regPull_q, regPull_d;
  logic countOn;
  logic evtNow;
  logic ocFault;

  // counter live in preheat and run, not in ignition
  assign countOn = (mode_q == MODE_PREHEAT) || (mode_q == MODE_RUN);
  // current comparison qualified by low-side conduction
  assign evtNow = currentAboveThreshold && gate.lowSideGate;
  assign ocFault = (evtCnt_q >= OC_EVENTS);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      // start only with good supply and released shutdown
      MODE_LOCKOUT: begin
        if (supplyAboveOn && shutdownBelowRelease) begin
          mode_d = MODE_PREHEAT;
        end
      end
      MODE_PREHEAT: begin
        if (ocFault) begin
          mode_d = MODE_FAULT;
        end else if (shutdownAboveTrip) begin
          mode_d = MODE_LOCKOUT;
        end else if (timerAboveUpper) begin
          mode_d = MODE_IGN_DISCH;
        end
      end
      // discharge ends at the lower level
      MODE_IGN_DISCH: begin
        if (timerBelowLower) begin
          mode_d = MODE_IGNITION;
        end
      end
      // shutdown and lifetime faults ignored here
      MODE_IGNITION: begin
        if (timerAboveUpper) begin
          mode_d = MODE_RUN;
        end
      end
      // counter overflow or lifetime fault latches off
      MODE_RUN: begin
        if (ocFault || lifetimeWindowFault) begin
          mode_d = MODE_FAULT;
        end else if (shutdownAboveTrip) begin
          mode_d = MODE_LOCKOUT;
        end
      end
      MODE_FAULT: begin
        if (shutdownAboveTrip) begin
          mode_d = MODE_LOCKOUT;
        end
      end
      default: mode_d = MODE_LOCKOUT;
    endcase
    // supply loss forces lockout from any mode
    if (!supplyAboveOn) begin
      mode_d = MODE_LOCKOUT;
    end
  end

  // event latch and up/down counter
  always_comb begin
    evtSeen_d = evtSeen_q || evtNow;
    evtCnt_d = evtCnt_q;
    if (!countOn) begin
      evtSeen_d = 1'b0;
      evtCnt_d = '0;
    end else if (gate.cycleEnd) begin
      evtSeen_d = 1'b0;
      if (evtSeen_q || evtNow) begin
        if (!ocFault) begin
          evtCnt_d = evtCnt_q + 7'h01;
        end
      end else if (evtCnt_q != 7'h00) begin
        evtCnt_d = evtCnt_q - 7'h01;
      end
    end
  end

  // soft start, high-side start and output qualifiers
  always_comb begin
    softCnt_d = softCnt_q;
    // count the early cycles at soft-start frequency
    if (mode_q == MODE_LOCKOUT) begin
      softCnt_d = 4'h0;
    end else if (gate.cycleEnd && softCnt_q != SOFT_CYCLES) begin
      softCnt_d = softCnt_q + 4'h1;
    end
    // high side latched on once its floating supply is up
    hsStarted_d = gate.oscRun && (hsStarted_q || floatingSupplyOk);
    // boost gate latched low in fault as well as lockout
    boostOk_d = (mode_d != MODE_LOCKOUT) && (mode_d != MODE_FAULT);
    // ramp node pulled while ignition current exceeds threshold during low-side conduction
    regPull_d = (mode_q == MODE_IGNITION) && evtNow;
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= MODE_LOCKOUT;
      evtCnt_q <= '0;
      evtSeen_q <= 1'b0;
      softCnt_q <= 4'h0;
      hsStarted_q <= 1'b0;
      boostOk_q <= 1'b0;
      regPull_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      evtCnt_q <= evtCnt_d;
      evtSeen_q <= evtSeen_d;
      softCnt_q <= softCnt_d;
      hsStarted_q <= hsStarted_d;
      boostOk_q <= boostOk_d;
      regPull_q <= regPull_d;
    end
  end

  // oscillator runs only outside lockout and fault
  assign gate.oscRun = (mode_q != MODE_LOCKOUT) && (mode_q != MODE_FAULT);
  assign gate.hsEnable = hsStarted_q;
  // shorter half period while soft start lasts
  assign gate.halfCount = (softCnt_q != SOFT_CYCLES) ?
                          CNT_W'(SOFT_HALF_CYC) : CNT_W'(PREHEAT_HALF_CYC);

  assign high_side_gate = gate.highSideGate;
  assign low_side_gate = gate.lowSideGate;
  assign bootstrapOn = gate.lowSideGate;
  assign boost_gate_out = boostOk_q && boostPwmIn;

  // grounded in lockout, discharge and fault
  assign timerDischarge = (mode_q == MODE_LOCKOUT) ||
                          (mode_q == MODE_IGN_DISCH) ||
                          (mode_q == MODE_FAULT);
  assign rampGround = (mode_q == MODE_PREHEAT) ||
                      (mode_q == MODE_IGN_DISCH) ||
                      (mode_q == MODE_FAULT) ||
                      (mode_q == MODE_LOCKOUT);
  assign ignitionRegPull = regPull_q;
  assign softStartActive = gate.oscRun && (softCnt_q != SOFT_CYCLES);
  // high gain in preheat and ignition
  assign boostHighGain = (mode_q == MODE_PREHEAT) ||
                         (mode_q == MODE_IGN_DISCH) ||
                         (mode_q == MODE_IGNITION);
  assign overcurrentCountEnable = countOn;
  assign lifetimeSenseEnable = (mode_q == MODE_RUN);
  assign modeState = mode_q;

endmodule // bms_sequencer

// ### testbench/ballast_mode_sequencer_test.sv
// self-checking bench for the ballast mode sequencer
// assumes the bridge model supplies current and bootstrap flags
`timescale 1ns/100ps
module ballast_mode_sequencer_test;
  import bms_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic supplyAboveOn = 1'b0;
  logic shutdownBelowRelease = 1'b0;
  logic shutdownAboveTrip = 1'b0;
  logic lifetimeWindowFault = 1'b0;
  logic timerAboveUpper = 1'b0;
  logic timerBelowLower = 1'b0;
  logic boostPwmIn = 1'b0;
  logic overloadCmd = 1'b0;
  logic floatingSupplyOk, currentAboveThreshold, high_side_gate;
  logic low_side_gate, bootstrapOn, boost_gate_out, timerDischarge;
  logic rampGround, ignitionRegPull, softStartActive, boostHighGain;
  logic overcurrentCountEnable, lifetimeSenseEnable;
  logic [2:0] modeState;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int lowRise[$];
  int highRise[$];
  int highFall[$];
  logic lowPrev = 1'b0;
  logic highPrev = 1'b0;
  logic [4:0] enTbl [6] = '{5'h18, 5'h0e, 5'h1c, 5'h04, 5'h03, 5'h18};
  always #5 clk_sys = ~clk_sys;
  bms_sequencer u_dut (.clk_sys, .rst, .supplyAboveOn, .shutdownBelowRelease,
    .shutdownAboveTrip, .lifetimeWindowFault, .floatingSupplyOk,
    .timerAboveUpper, .timerBelowLower, .currentAboveThreshold, .boostPwmIn,
    .high_side_gate, .low_side_gate, .bootstrapOn, .boost_gate_out,
    .timerDischarge, .rampGround, .ignitionRegPull, .softStartActive,
    .boostHighGain, .overcurrentCountEnable, .lifetimeSenseEnable,
    .modeState);
  bms_bridge_model u_bridge (.clk_sys, .rst, .low_side_gate, .overloadCmd,
    .floatingSupplyOk, .currentAboveThreshold);
  // random boost demand and gate edge log
  always @(posedge clk_sys) begin
    boostPwmIn <= 1'($urandom);
    cyc <= cyc + 1;
    lowPrev <= low_side_gate;
    highPrev <= high_side_gate;
    if (low_side_gate && !lowPrev) lowRise.push_back(cyc);
    if (high_side_gate && !highPrev) highRise.push_back(cyc);
    if (!high_side_gate && highPrev) highFall.push_back(cyc);
  end
  task automatic cmp(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic waitc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // mode and mode-derived outputs against the model
  task automatic chkMode(int m);
    cmp("mode", 16'(modeState), 16'(m));
    cmp("enables", 16'({timerDischarge, rampGround, boostHighGain,
      overcurrentCountEnable, lifetimeSenseEnable}), 16'(enTbl[m]));
    cmp("boost", 16'(boost_gate_out), 16'(boostPwmIn && m > 0 && m < 5));
    cmp("bootstrap", 16'(bootstrapOn), 16'(low_side_gate));
  endtask
  task automatic test_done;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  // main sequence
  initial begin
    void'($urandom(38171));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    waitc(3);
    chkMode(0);
    cmp("gates", 16'({high_side_gate, low_side_gate}), 16'h0);
    @(posedge clk_sys) supplyAboveOn <= 1'b1;
    waitc(20);
    chkMode(0);
    @(posedge clk_sys) shutdownBelowRelease <= 1'b1;
    waitc(3);
    chkMode(1);
    cmp("soft", 16'(softStartActive), 16'h1);
    for (int i = 0; i < 30000 && lowRise.size() < 12; i++) waitc(1);
    waitc(2000);
    cmp("rises", 16'(lowRise.size() >= 12), 16'h1);
    cmp("softPer", 16'(lowRise[2] - lowRise[1]), 16'(2 * SOFT_HALF_CYC));
    cmp("per", 16'(lowRise[11] - lowRise[10]), 16'(2 * PREHEAT_HALF_CYC));
    cmp("soft", 16'(softStartActive), 16'h0);
    cmp("hsLate", 16'(highRise[0] > lowRise[2]), 16'h1);
    cmp("hsWidth", 16'(highFall[$] - highRise[$]),
      16'(PREHEAT_HALF_CYC - DEAD_CYC));
    @(posedge clk_sys) timerAboveUpper <= 1'b1;
    @(posedge clk_sys) timerAboveUpper <= 1'b0;
    waitc(1);
    chkMode(2);
    @(posedge clk_sys) timerBelowLower <= 1'b1;
    @(posedge clk_sys) timerBelowLower <= 1'b0;
    waitc(1);
    chkMode(3);
    @(posedge clk_sys) begin
      shutdownAboveTrip <= 1'b1;
      lifetimeWindowFault <= 1'b1;
      shutdownBelowRelease <= 1'b0;
    end
    waitc(5);
    chkMode(3);
    @(posedge clk_sys) begin
      shutdownAboveTrip <= 1'b0;
      lifetimeWindowFault <= 1'b0;
      overloadCmd <= 1'b1;
    end
    // let any low-side on-time run out, then check the qualification
    waitc(1);
    for (int i = 0; i < 3000 && low_side_gate; i++) waitc(1);
    waitc(2);
    cmp("ignQual", 16'(ignitionRegPull), 16'h0);
    for (int i = 0; i < 3000 && !low_side_gate; i++) waitc(1);
    waitc(4);
    cmp("ignReg", 16'(ignitionRegPull), 16'h1);
    @(posedge clk_sys) overloadCmd <= 1'b0;
    waitc(2100);
    cmp("ignReg", 16'(ignitionRegPull), 16'h0);
    @(posedge clk_sys) timerAboveUpper <= 1'b1;
    @(posedge clk_sys) timerAboveUpper <= 1'b0;
    waitc(3);
    chkMode(4);
    @(posedge clk_sys) lifetimeWindowFault <= 1'b1;
    @(posedge clk_sys) lifetimeWindowFault <= 1'b0;
    waitc(3);
    chkMode(5);
    cmp("gates", 16'({high_side_gate, low_side_gate}), 16'h0);
    @(posedge clk_sys) shutdownAboveTrip <= 1'b1;
    @(posedge clk_sys) shutdownAboveTrip <= 1'b0;
    waitc(10);
    chkMode(0);
    @(posedge clk_sys) shutdownBelowRelease <= 1'b1;
    waitc(3);
    chkMode(1);
    @(posedge clk_sys) supplyAboveOn <= 1'b0;
    waitc(3);
    chkMode(0);
    cmp("gates", 16'({high_side_gate, low_side_gate}), 16'h0);
    test_done();
  end
endmodule // ballast_mode_sequencer_test

// ### testbench/bms_bridge_model.sv
// half-bridge and lamp stage as seen through the sense comparators
// assumes the gate inputs come straight from the sequencer
`timescale 1ns/100ps
module bms_bridge_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic low_side_gate,
  input wire logic overloadCmd,
  output logic floatingSupplyOk,
  output logic currentAboveThreshold
);
  logic [1:0] chargeCnt = 2'h0;
  logic lowPrev = 1'b0;
  // bootstrap charges over three low-side on-times
  always @(posedge clk_sys) begin
    lowPrev <= low_side_gate;
    if (rst) chargeCnt <= 2'h0;
    else if (lowPrev && !low_side_gate && chargeCnt != 2'h3)
      chargeCnt <= chargeCnt + 2'h1;
    // overload shows as a steady current level; the device must gate it
    currentAboveThreshold <= overloadCmd;
  end
  assign floatingSupplyOk = (chargeCnt == 2'h3);
endmodule // bms_bridge_model

// ### testbench/bms_seq_monitor.sv
// checker on the mode sequencer top ports
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/100ps
module bms_seq_monitor
  import bms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic supplyAboveOn,
  input wire logic shutdownBelowRelease,
  input wire logic shutdownAboveTrip,
  input wire logic timerAboveUpper,
  input wire logic currentAboveThreshold,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic boost_gate_out,
  input wire logic timerDischarge,
  input wire logic rampGround,
  input wire logic ignitionRegPull,
  input wire logic overcurrentCountEnable,
  input wire logic [2:0] modeState
);
  logic [7:0] lowRun_q;
  logic [7:0] lowRun_d;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // count cycles with both gates off
  always_comb begin
    lowRun_d = lowRun_q;
    if (high_side_gate || low_side_gate) lowRun_d = 8'h00;
    else if (lowRun_q != 8'hff) lowRun_d = lowRun_q + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    lowRun_q <= rst ? 8'h00 : lowRun_d;
  end
  sequence s_gatesOff;
    !high_side_gate && !low_side_gate;
  endsequence
  property p_lockHold;
    modeState == 3'h0 && $past(modeState) == 3'h0 |->
      s_gatesOff ##0 timerDischarge;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lockout hold");
  property p_start;
    modeState == 3'h0 && supplyAboveOn && shutdownBelowRelease |=>
      modeState == 3'h1;
  endproperty
  a_start: assert property (p_start) else $error("no preheat start");
  property p_dead;
    $rose(high_side_gate) |-> lowRun_q == DEAD_CYC && !low_side_gate;
  endproperty
  a_dead: assert property (p_dead) else $error("dead interval");
  property p_preheat;
    modeState == 3'h1 |->
      !timerDischarge && rampGround && overcurrentCountEnable;
  endproperty
  a_preheat: assert property (p_preheat) else $error("preheat switches");
  property p_ignEntry;
    modeState == 3'h1 && timerAboveUpper && supplyAboveOn &&
      !shutdownAboveTrip |=>
      (modeState == 3'h2 && timerDischarge) || modeState == 3'h5;
  endproperty
  a_ignEntry: assert property (p_ignEntry) else $error("ignition entry");
  property p_ignition;
    modeState == 3'h3 |->
      !timerDischarge && !rampGround && !overcurrentCountEnable;
  endproperty
  a_ignition: assert property (p_ignition) else $error("ignition switches");
  property p_run;
    modeState == 3'h3 && timerAboveUpper && supplyAboveOn |=>
      modeState == 3'h4 && overcurrentCountEnable;
  endproperty
  a_run: assert property (p_run) else $error("run entry");
  property p_ignHold;
    modeState == 3'h3 && supplyAboveOn && !timerAboveUpper |=>
      modeState == 3'h3;
  endproperty
  a_ignHold: assert property (p_ignHold) else $error("ignition left");
  property p_ignReg;
    modeState == 3'h3 && currentAboveThreshold && low_side_gate |=>
      ignitionRegPull;
  endproperty
  a_ignReg: assert property (p_ignReg) else $error("no regulation");
  property p_ignQual;
    !low_side_gate |=> !ignitionRegPull;
  endproperty
  a_ignQual: assert property (p_ignQual) else $error("unqualified pull");
  property p_runNoReg;
    modeState == 3'h4 && $past(modeState) == 3'h4 |-> !ignitionRegPull;
  endproperty
  a_runNoReg: assert property (p_runNoReg) else $error("run regulation");
  property p_fault;
    modeState == 3'h5 && $past(modeState) == 3'h5 |->
      s_gatesOff ##0 !boost_gate_out && timerDischarge && rampGround;
  endproperty
  a_fault: assert property (p_fault) else $error("fault outputs");
  property p_faultExit;
    modeState == 3'h5 && (!supplyAboveOn || shutdownAboveTrip) |=>
      modeState == 3'h0;
  endproperty
  a_faultExit: assert property (p_faultExit) else $error("fault exit");
endmodule // bms_seq_monitor
bind bms_sequencer bms_seq_monitor u_mon (.clk_sys, .rst, .supplyAboveOn,
  .shutdownBelowRelease, .shutdownAboveTrip, .timerAboveUpper,
  .currentAboveThreshold, .high_side_gate, .low_side_gate, .boost_gate_out,
  .timerDischarge, .rampGround, .ignitionRegPull, .overcurrentCountEnable,
  .modeState);
